// File: rtl/pcfg_params.svh
// Register indices, reset values and field positions of the port config bank
`ifndef PCFG_PARAMS_SVH
`define PCFG_PARAMS_SVH

// Register indices; byte address is four times the index
`define PCFG_IDX_B1 10'h0B1
`define PCFG_IDX_B2 10'h0B2
`define PCFG_IDX_B3 10'h0B3
`define PCFG_IDX_B4 10'h0B4
`define PCFG_IDX_PAGE 10'h0C0
`define PCFG_IDX_MODE_STAT 10'h0C1

// Reset values
`define PCFG_RST_P0_MS1 8'hFF
`define PCFG_RST_P0_MS2 8'h00
`define PCFG_RST_P0_THR 8'h00
`define PCFG_RST_P0_SLEW 8'h00
`define PCFG_RST_P1_MS1 8'hFF
`define PCFG_RST_P1_MS2 8'h00
`define PCFG_RST_P1_THR 8'h00
`define PCFG_RST_P1_SLEW 8'h00
`define PCFG_RST_PAGE 1'b0

// Page values and field positions
`define PCFG_PAGE_0 1'b0
`define PCFG_PAGE_1 1'b1
`define PCFG_PAGE_BIT 0
`define PCFG_BYTE_LANE 0
`define PCFG_ALIGN_OK 2'h0
`define PCFG_ADDR_W 12

`endif

// File: rtl/pcfg_pkg.sv
// Types shared by the port pin configuration bank
`default_nettype none

package pcfg_pkg;

  // Pin mode as {first select bit, second select bit}
  typedef enum logic [1:0] {
    PCFG_MODE_QUASI = 2'h0,
    PCFG_MODE_PUSH_PULL = 2'h1,
    PCFG_MODE_INPUT_ONLY = 2'h2,
    PCFG_MODE_OPEN_DRAIN = 2'h3
  } pcfg_mode_e;

  // Register selected by address and page
  typedef enum logic [3:0] {
    PCFG_SEL_NONE = 4'h0,
    PCFG_SEL_P0_MS1 = 4'h1,
    PCFG_SEL_P0_THR = 4'h3,
    PCFG_SEL_P0_MS2 = 4'h2,
    PCFG_SEL_P0_SLEW = 4'h6,
    PCFG_SEL_P1_MS1 = 4'h7,
    PCFG_SEL_P1_THR = 4'h5,
    PCFG_SEL_P1_MS2 = 4'h4,
    PCFG_SEL_RSVD = 4'hC,
    PCFG_SEL_PAGE = 4'hD,
    PCFG_SEL_STAT = 4'hF
  } pcfg_sel_e;

  // Per-port configuration handed to the pad ring
  typedef struct packed {
    logic [15:0] mode;
    logic [7:0] schmitt;
    logic [7:0] fast_slew;
  } pcfg_port_s;

endpackage

`default_nettype wire

// File: rtl/pcfg_regs.sv
// Paged configuration register bank for two 8-pin ports, APB slave
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "pcfg_params.svh"

module pcfg_regs #(
  parameter int ADDR_W = `PCFG_ADDR_W
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output var pcfg_pkg::pcfg_port_s port0_cfg_o,
  output var pcfg_pkg::pcfg_port_s port1_cfg_o
);

  logic [7:0] p0_ms1_q;
  logic [7:0] p0_ms2_q;
  logic [7:0] p0_thr_q;
  logic [7:0] p0_slew_q;
  logic [7:0] p1_ms1_q;
  logic [7:0] p1_ms2_q;
  logic [7:0] p1_thr_q;
  logic page_q;
  logic setup_w;
  logic access_w;
  logic wr_en_w;
  logic [7:0] wbyte_w;
  pcfg_pkg::pcfg_sel_e sel_w;

  // Address plus page to register; misaligned or unknown goes nowhere
  function automatic pcfg_pkg::pcfg_sel_e decode_sel(
    input logic [ADDR_W-1:0] addr,
    input logic page
  );
    pcfg_pkg::pcfg_sel_e s;
    s = pcfg_pkg::PCFG_SEL_NONE;
    if (addr[1:0] == `PCFG_ALIGN_OK)
    begin
      case (addr[ADDR_W-1:2])
        `PCFG_IDX_B1:
          s = (page == `PCFG_PAGE_1) ? pcfg_pkg::PCFG_SEL_P0_THR
                                     : pcfg_pkg::PCFG_SEL_P0_MS1;
        `PCFG_IDX_B2:
          s = (page == `PCFG_PAGE_1) ? pcfg_pkg::PCFG_SEL_P0_SLEW
                                     : pcfg_pkg::PCFG_SEL_P0_MS2;
        `PCFG_IDX_B3:
          s = (page == `PCFG_PAGE_1) ? pcfg_pkg::PCFG_SEL_P1_THR
                                     : pcfg_pkg::PCFG_SEL_P1_MS1;
        // Page-1 slot at B4 is not held here; reads zero, writes dropped
        `PCFG_IDX_B4:
          s = (page == `PCFG_PAGE_1) ? pcfg_pkg::PCFG_SEL_RSVD
                                     : pcfg_pkg::PCFG_SEL_P1_MS2;
        `PCFG_IDX_PAGE: s = pcfg_pkg::PCFG_SEL_PAGE;
        `PCFG_IDX_MODE_STAT: s = pcfg_pkg::PCFG_SEL_STAT;
        default: s = pcfg_pkg::PCFG_SEL_NONE;
      endcase
    end
    return s;
  endfunction

  // Interleave the two select bytes into per-pin mode pairs
  function automatic logic [15:0] pack_modes(
    input logic [7:0] first,
    input logic [7:0] second
  );
    logic [15:0] m;
    m = 16'h0000;
    for (int n = 0; n < 8; n++)
    begin
      m[2*n +: 2] = {first[n], second[n]};
    end
    return m;
  endfunction

  assign setup_w = psel_i & ~penable_i;
  assign access_w = psel_i & penable_i & pready_o;
  assign sel_w = decode_sel(paddr_i, page_q);
  assign wbyte_w = pwdata_i[8*`PCFG_BYTE_LANE +: 8];
  // Writes land only on the completing edge with the low lane strobed
  assign wr_en_w = access_w & pwrite_i & pstrb_i[`PCFG_BYTE_LANE];

  // Page control
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      page_q <= `PCFG_RST_PAGE;
    else if (wr_en_w && sel_w == pcfg_pkg::PCFG_SEL_PAGE)
      page_q <= wbyte_w[`PCFG_PAGE_BIT];
  end

  // Port 0 mode selects
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      p0_ms1_q <= `PCFG_RST_P0_MS1;
      p0_ms2_q <= `PCFG_RST_P0_MS2;
    end
    else if (wr_en_w)
    begin
      if (sel_w == pcfg_pkg::PCFG_SEL_P0_MS1)
        p0_ms1_q <= wbyte_w;
      if (sel_w == pcfg_pkg::PCFG_SEL_P0_MS2)
        p0_ms2_q <= wbyte_w;
    end
  end

  // Port 0 threshold and slew
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      p0_thr_q <= `PCFG_RST_P0_THR;
      p0_slew_q <= `PCFG_RST_P0_SLEW;
    end
    else if (wr_en_w)
    begin
      if (sel_w == pcfg_pkg::PCFG_SEL_P0_THR)
        p0_thr_q <= wbyte_w;
      if (sel_w == pcfg_pkg::PCFG_SEL_P0_SLEW)
        p0_slew_q <= wbyte_w;
    end
  end

  // Port 1 mode selects; first resets to ones so pins start input-only
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      p1_ms1_q <= `PCFG_RST_P1_MS1;
      p1_ms2_q <= `PCFG_RST_P1_MS2;
    end
    else if (wr_en_w)
    begin
      if (sel_w == pcfg_pkg::PCFG_SEL_P1_MS1)
        p1_ms1_q <= wbyte_w;
      if (sel_w == pcfg_pkg::PCFG_SEL_P1_MS2)
        p1_ms2_q <= wbyte_w;
    end
  end

  // Port 1 threshold
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      p1_thr_q <= `PCFG_RST_P1_THR;
    else if (wr_en_w && sel_w == pcfg_pkg::PCFG_SEL_P1_THR)
      p1_thr_q <= wbyte_w;
  end

  // Pad-side config, one cycle behind the registers to keep outputs on flops
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      port0_cfg_o <= '{mode: pack_modes(`PCFG_RST_P0_MS1, `PCFG_RST_P0_MS2),
                       schmitt: `PCFG_RST_P0_THR, fast_slew: `PCFG_RST_P0_SLEW};
      port1_cfg_o <= '{mode: pack_modes(`PCFG_RST_P1_MS1, `PCFG_RST_P1_MS2),
                       schmitt: `PCFG_RST_P1_THR, fast_slew: `PCFG_RST_P1_SLEW};
    end
    else
    begin
      port0_cfg_o.mode <= pack_modes(p0_ms1_q, p0_ms2_q);
      port0_cfg_o.schmitt <= p0_thr_q;
      port0_cfg_o.fast_slew <= p0_slew_q;
      port1_cfg_o.mode <= pack_modes(p1_ms1_q, p1_ms2_q);
      port1_cfg_o.schmitt <= p1_thr_q;
      // No port-1 slew control in this bank, pads keep normal edges
      port1_cfg_o.fast_slew <= `PCFG_RST_P1_SLEW;
    end
  end

  // APB answer built in setup so the access phase never waits
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else if (setup_w)
    begin
      pready_o <= 1'b1;
      pslverr_o <= (sel_w == pcfg_pkg::PCFG_SEL_NONE);
    end
    else
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // Read data; narrow registers sit in the low byte, upper bits zero
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      prdata_o <= 32'h0000_0000;
    else if (setup_w && !pwrite_i)
    begin
      case (sel_w)
        pcfg_pkg::PCFG_SEL_P0_MS1: prdata_o <= {24'h000000, p0_ms1_q};
        pcfg_pkg::PCFG_SEL_P0_MS2: prdata_o <= {24'h000000, p0_ms2_q};
        pcfg_pkg::PCFG_SEL_P0_THR: prdata_o <= {24'h000000, p0_thr_q};
        pcfg_pkg::PCFG_SEL_P0_SLEW: prdata_o <= {24'h000000, p0_slew_q};
        pcfg_pkg::PCFG_SEL_P1_MS1: prdata_o <= {24'h000000, p1_ms1_q};
        pcfg_pkg::PCFG_SEL_P1_MS2: prdata_o <= {24'h000000, p1_ms2_q};
        pcfg_pkg::PCFG_SEL_P1_THR: prdata_o <= {24'h000000, p1_thr_q};
        pcfg_pkg::PCFG_SEL_PAGE: prdata_o <= {31'h00000000, page_q};
        // Live pin modes as seen by the pads
        pcfg_pkg::PCFG_SEL_STAT: prdata_o <= {port1_cfg_o.mode, port0_cfg_o.mode};
        default: prdata_o <= 32'h0000_0000;
      endcase
    end
    else if (!psel_i)
      prdata_o <= 32'h0000_0000;
  end

  // Checks
  property p_p0_thr_follows;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_en_w && sel_w == pcfg_pkg::PCFG_SEL_P0_THR)
      |-> ##2 (port0_cfg_o.schmitt == $past(wbyte_w, 2));
  endproperty
  a_p0_thr_follows: assert property (p_p0_thr_follows)
    else $error("port0 threshold output did not follow write");

  property p_p1_thr_follows;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_en_w && sel_w == pcfg_pkg::PCFG_SEL_P1_THR)
      |-> ##2 (port1_cfg_o.schmitt == $past(wbyte_w, 2));
  endproperty
  a_p1_thr_follows: assert property (p_p1_thr_follows)
    else $error("port1 threshold output did not follow write");

  property p_p0_slew_follows;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_en_w && sel_w == pcfg_pkg::PCFG_SEL_P0_SLEW)
      |-> ##2 (port0_cfg_o.fast_slew == $past(wbyte_w, 2));
  endproperty
  a_p0_slew_follows: assert property (p_p0_slew_follows)
    else $error("port0 slew output did not follow write");

  property p_p0_mode_pair;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_en_w && sel_w == pcfg_pkg::PCFG_SEL_P0_MS2)
      |-> ##2 (port0_cfg_o.mode[0] == $past(wbyte_w[0], 2))
              && (port0_cfg_o.mode[1] == p0_ms1_q[0]);
  endproperty
  a_p0_mode_pair: assert property (p_p0_mode_pair)
    else $error("port0 pin0 mode not built from both selects");

  property p_p1_mode_pair;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_en_w && sel_w == pcfg_pkg::PCFG_SEL_P1_MS1)
      |-> ##2 (port1_cfg_o.mode[15] == $past(wbyte_w[7], 2))
              && (port1_cfg_o.mode[14] == p1_ms2_q[7]);
  endproperty
  a_p1_mode_pair: assert property (p_p1_mode_pair)
    else $error("port1 pin7 mode not built from both selects");

  property p_p1_reset_input_only;
    @(posedge core_clk_i)
    $fell(sys_rst_i) |-> (p1_ms1_q == `PCFG_RST_P1_MS1) && (p1_ms2_q == `PCFG_RST_P1_MS2)
      && (port1_cfg_o.mode[1:0] == pcfg_pkg::PCFG_MODE_INPUT_ONLY);
  endproperty
  a_p1_reset_input_only: assert property (p_p1_reset_input_only)
    else $error("port1 did not leave reset in input-only mode");

  property p_page0_b2_keeps_slew;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_en_w && paddr_i[ADDR_W-1:2] == `PCFG_IDX_B2 && paddr_i[1:0] == `PCFG_ALIGN_OK
      && page_q == `PCFG_PAGE_0)
      |=> $stable(p0_slew_q) && (p0_ms2_q == $past(wbyte_w));
  endproperty
  a_page0_b2_keeps_slew: assert property (p_page0_b2_keeps_slew)
    else $error("page 0 write at B2 reached the wrong register");

  property p_mode_encoding;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    ##1 (port0_cfg_o.mode[5:4] == {$past(p0_ms1_q[2]), $past(p0_ms2_q[2])});
  endproperty
  a_mode_encoding: assert property (p_mode_encoding)
    else $error("mode pair order wrong on port0 pin2");

  property p_page1_b1_keeps_ms1;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_en_w && paddr_i[ADDR_W-1:2] == `PCFG_IDX_B1 && paddr_i[1:0] == `PCFG_ALIGN_OK
      && page_q == `PCFG_PAGE_1)
      |=> $stable(p0_ms1_q) && (p0_thr_q == $past(wbyte_w));
  endproperty
  a_page1_b1_keeps_ms1: assert property (p_page1_b1_keeps_ms1)
    else $error("page 1 write at B1 reached the wrong register");

  property p_p1_thr_reset;
    @(posedge core_clk_i)
    $fell(sys_rst_i) |-> (p1_thr_q == `PCFG_RST_P1_THR)
      && (port1_cfg_o.schmitt == `PCFG_RST_P1_THR);
  endproperty
  a_p1_thr_reset: assert property (p_p1_thr_reset)
    else $error("port1 threshold not zero after reset");

  property p_p0_ms2_reset;
    @(posedge core_clk_i)
    $fell(sys_rst_i) |-> (p0_ms2_q == `PCFG_RST_P0_MS2)
      && (port0_cfg_o.fast_slew == `PCFG_RST_P0_SLEW);
  endproperty
  a_p0_ms2_reset: assert property (p_p0_ms2_reset)
    else $error("port0 second mode select not zero after reset");

  property p_page1_b2_read;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (setup_w && !pwrite_i && paddr_i[ADDR_W-1:2] == `PCFG_IDX_B2
      && paddr_i[1:0] == `PCFG_ALIGN_OK && page_q == `PCFG_PAGE_1)
      |=> (prdata_o == {24'h000000, $past(p0_slew_q)});
  endproperty
  a_page1_b2_read: assert property (p_page1_b2_read)
    else $error("page 1 read at B2 did not return the slew register");

  property p_rsvd_write_dropped;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_en_w && paddr_i[ADDR_W-1:2] == `PCFG_IDX_B4 && paddr_i[1:0] == `PCFG_ALIGN_OK
      && page_q == `PCFG_PAGE_1)
      |=> $stable(p1_ms2_q) && $stable(p1_ms1_q);
  endproperty
  a_rsvd_write_dropped: assert property (p_rsvd_write_dropped)
    else $error("page 1 write at B4 changed a port1 mode select");

  property p_apb_no_wait;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    setup_w |=> pready_o ##1 !pready_o;
  endproperty
  a_apb_no_wait: assert property (p_apb_no_wait)
    else $error("apb answer not exactly one access cycle");

endmodule

`default_nettype wire

// File: tb/test_port_pin_config_regs.sv
// Self-checking bench for the paged port configuration registers
`timescale 1ns/1ns
`default_nettype none
`include "pcfg_params.svh"

module test_port_pin_config_regs;
  logic core_clk_i;
  logic sys_rst_i;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  pcfg_pkg::pcfg_port_s p0_cfg, p1_cfg;
  int failures;
  int samples_checked;
  int cycles;

  pcfg_regs u_dut (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .psel_i(psel),
    .penable_i(penable),
    .pwrite_i(pwrite),
    .paddr_i(paddr),
    .pwdata_i(pwdata),
    .pstrb_i(pstrb),
    .prdata_o(prdata),
    .pready_o(pready),
    .pslverr_o(pslverr),
    .port0_cfg_o(p0_cfg),
    .port1_cfg_o(p1_cfg)
  );

  initial
  begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  function automatic logic [11:0] ba(input logic [9:0] idx);
    return {idx, 2'h0};
  endfunction

  // Pad mode pairs worked out independently of the design
  function automatic logic [15:0] modes(input logic [7:0] f, input logic [7:0] s);
    logic [15:0] m;
    for (int n = 0; n < 8; n++)
    begin
      m[2*n +: 2] = {f[n], s[n]};
    end
    return m;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Wait for pready is unbounded here; the cycle ceiling cuts a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] st, output logic [31:0] r, output logic e);
    @(posedge core_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    pstrb <= st;
    @(posedge core_clk_i);
    penable <= 1'b1;
    @(posedge core_clk_i);
    while (pready !== 1'b1)
    begin
      @(posedge core_clk_i);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 4'hF, rd, err);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, a, 8'h00, 4'hF, rd, err);
    chk(rd, exp);
    chk({31'h00000000, err}, {31'h00000000, exp_err});
  endtask

  // Pads lag the register by a cycle
  task automatic settle();
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask

  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      conclude();
    end
  end

  initial
  begin
    sys_rst_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    failures = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (16) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    settle();
    chk(p0_cfg, {16'hAAAA, 8'h00, 8'h00});
    chk(p1_cfg, {16'hAAAA, 8'h00, 8'h00});
    rdc(ba(`PCFG_IDX_B1), 32'h000000FF, 1'b0);
    rdc(ba(`PCFG_IDX_B2), 32'h00000000, 1'b0);
    rdc(ba(`PCFG_IDX_B3), 32'h000000FF, 1'b0);
    rdc(ba(`PCFG_IDX_B4), 32'h00000000, 1'b0);
    rdc(ba(`PCFG_IDX_MODE_STAT), 32'hAAAAAAAA, 1'b0);
    wr(ba(`PCFG_IDX_PAGE), 8'h01);
    rdc(ba(`PCFG_IDX_B1), 32'h00000000, 1'b0);
    rdc(ba(`PCFG_IDX_B2), 32'h00000000, 1'b0);
    rdc(ba(`PCFG_IDX_B3), 32'h00000000, 1'b0);
    wr(ba(`PCFG_IDX_B1), 8'h5A);
    wr(ba(`PCFG_IDX_B2), 8'hC3);
    wr(ba(`PCFG_IDX_B3), 8'h3C);
    wr(ba(`PCFG_IDX_B4), 8'h77);
    settle();
    chk({24'h000000, p0_cfg.schmitt}, 32'h0000005A);
    chk({24'h000000, p0_cfg.fast_slew}, 32'h000000C3);
    chk({24'h000000, p1_cfg.schmitt}, 32'h0000003C);
    chk(p1_cfg.mode, 32'h0000AAAA);
    rdc(ba(`PCFG_IDX_B4), 32'h00000000, 1'b0);
    rdc(ba(`PCFG_IDX_B2), 32'h000000C3, 1'b0);
    wr(ba(`PCFG_IDX_PAGE), 8'h00);
    rdc(ba(`PCFG_IDX_B1), 32'h000000FF, 1'b0);
    rdc(ba(`PCFG_IDX_B2), 32'h00000000, 1'b0);
    rdc(ba(`PCFG_IDX_B3), 32'h000000FF, 1'b0);
    wr(ba(`PCFG_IDX_B1), 8'h0F);
    wr(ba(`PCFG_IDX_B2), 8'h33);
    wr(ba(`PCFG_IDX_B3), 8'h55);
    wr(ba(`PCFG_IDX_B4), 8'h33);
    settle();
    chk(p0_cfg.mode, modes(8'h0F, 8'h33));
    chk(p1_cfg.mode, modes(8'h55, 8'h33));
    chk(32'(p0_cfg.mode[1:0]), 32'(pcfg_pkg::PCFG_MODE_OPEN_DRAIN));
    chk(32'(p0_cfg.mode[5:4]), 32'(pcfg_pkg::PCFG_MODE_INPUT_ONLY));
    chk(32'(p0_cfg.mode[9:8]), 32'(pcfg_pkg::PCFG_MODE_PUSH_PULL));
    chk(32'(p0_cfg.mode[13:12]), 32'(pcfg_pkg::PCFG_MODE_QUASI));
    chk({24'h000000, p0_cfg.schmitt}, 32'h0000005A);
    rdc(ba(`PCFG_IDX_MODE_STAT), {modes(8'h55, 8'h33), modes(8'h0F, 8'h33)}, 1'b0);
    // Refused writes must leave the stored value alone
    apb(1'b1, ba(`PCFG_IDX_B2) + 12'h001, 8'hAA, 4'hF, rd, err);
    chk({31'h00000000, err}, 32'h00000001);
    apb(1'b1, ba(`PCFG_IDX_B2), 8'hAA, 4'hE, rd, err);
    chk({31'h00000000, err}, 32'h00000000);
    wr(ba(10'h0B0), 8'hAA);
    rdc(ba(10'h0B0), 32'h00000000, 1'b1);
    wr(ba(`PCFG_IDX_MODE_STAT), 8'h00);
    rdc(ba(`PCFG_IDX_B2), 32'h00000033, 1'b0);
    rdc(ba(`PCFG_IDX_MODE_STAT), {modes(8'h55, 8'h33), modes(8'h0F, 8'h33)}, 1'b0);
    wr(ba(`PCFG_IDX_PAGE), 8'h01);
    @(posedge core_clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    settle();
    chk(p0_cfg, {16'hAAAA, 8'h00, 8'h00});
    chk(p1_cfg, {16'hAAAA, 8'h00, 8'h00});
    rdc(ba(`PCFG_IDX_PAGE), 32'h00000000, 1'b0);
    rdc(ba(`PCFG_IDX_B3), 32'h000000FF, 1'b0);
    conclude();
  end
endmodule

`default_nettype wire
